// ===== src/ptx_mac_tx.sv
`timescale 1ns/100ps
`include "ptx_regs.svh"

module ptx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock, // client clock
  input wire logic nrst, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // not empty
  input wire logic out_ready, // read request
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;

  assign in_ready = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign out_valid = wp_reg != rp_reg;
  assign out_data = mem[rp_reg[AW-1:0]];

  // storage write
  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers with wrap bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

module ptx_mac_tx (
  input wire logic clock, // 200 MHz client clock
  input wire logic nrst, // async reset, active low
  ptx_if.dev link, // from the client
  input wire logic [95:0] time_of_day_source, // sec 48, ns 32, frac 16
  input wire logic [63:0] asym_corr, // asymmetry, ns scaled by 2^16
  input wire logic [63:0] pdelay_corr, // mean path delay, ns scaled
  output logic [7:0] pcs_byte, // octet toward the pcs
  output logic pcs_valid, // octet valid
  output logic pcs_sof, // first preamble octet
  output logic pcs_eof // last frame octet
);

  ptx_pkg::ptx_beat_t f_out;
  ptx_pkg::ptx_beat_t w_reg;
  ptx_pkg::ptx_side_t side_reg;
  ptx_pkg::ptx_tx_state_t state_reg;
  logic f_valid;
  logic f_ready;
  logic ld;
  logic have_reg;
  logic [5:0] bidx_reg;
  logic [5:0] last_idx;
  logic at_end;
  logic emit;
  logic [15:0] pos_reg;
  logic [15:0] rel;
  logic [3:0] gap_reg;
  logic [95:0] ts_reg;
  logic [95:0] tod_adj;
  logic [32:0] ns_sum;
  logic [31:0] resid;
  logic [63:0] corr_new;
  logic [15:0] new_sum;
  logic [15:0] ext_new;
  logic [79:0] ts_sh;
  logic [63:0] corr_sh;
  logic [15:0] ext_sh;
  logic [15:0] k_ts;
  logic [15:0] k_corr;
  logic [15:0] k_ext;
  logic one;
  logic [7:0] byte_next;
  logic [`PTX_DATA_W-1:0] raw_sh;

  // ones-complement 16-bit add
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return 16'(s[15:0] + {15'h0, s[16]});
  endfunction

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  ptx_fifo #(
    .WIDTH($bits(ptx_pkg::ptx_beat_t)),
    .DEPTH(`PTX_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(link.valid),
    .in_ready(link.ready),
    .in_data(link.beat),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_out)
  );

  // ----------------------------------------------------------------
  // word fetch and octet stepping
  // ----------------------------------------------------------------
  assign last_idx = w_reg.eop ? 6'(6'h3F - w_reg.empty) : 6'h3F;
  assign at_end = bidx_reg == last_idx;
  assign emit = (state_reg == ptx_pkg::PTX_ST_PRE) ||
                (state_reg == ptx_pkg::PTX_ST_DATA && have_reg);
  assign f_ready = (state_reg == ptx_pkg::PTX_ST_IDLE) ||
                   (state_reg == ptx_pkg::PTX_ST_DATA &&
                    (!have_reg || (at_end && !w_reg.eop)));
  assign ld = f_valid && f_ready;

  // frame sequencing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ptx_pkg::PTX_ST_IDLE;
    end else begin
      unique case (state_reg)
        ptx_pkg::PTX_ST_IDLE: begin
          if (ld && f_out.sop) begin
            state_reg <= link.pt_en ? ptx_pkg::PTX_ST_DATA : ptx_pkg::PTX_ST_PRE;
          end
        end
        ptx_pkg::PTX_ST_PRE: begin
          if (pos_reg == `PTX_PRE_LEN - 16'h0001) begin
            state_reg <= ptx_pkg::PTX_ST_DATA;
          end
        end
        ptx_pkg::PTX_ST_DATA: begin
          if (have_reg && at_end && w_reg.eop) begin
            state_reg <= ptx_pkg::PTX_ST_GAP;
          end
        end
        ptx_pkg::PTX_ST_GAP: begin
          if (gap_reg == `PTX_IFG_OCT - 4'h1) begin
            state_reg <= ptx_pkg::PTX_ST_IDLE;
          end
        end
      endcase
    end
  end

  // current word, octet index, frame position
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_reg <= '0;
      have_reg <= 1'b0;
      bidx_reg <= 6'h00;
      pos_reg <= 16'h0000;
      gap_reg <= 4'h0;
    end else begin
      if (ld) begin
        w_reg <= f_out;
        have_reg <= 1'b1;
        bidx_reg <= 6'h00;
      end else if (state_reg == ptx_pkg::PTX_ST_DATA && have_reg) begin
        have_reg <= !at_end;
        bidx_reg <= 6'(bidx_reg + 6'h01);
      end
      if (state_reg == ptx_pkg::PTX_ST_IDLE) begin
        pos_reg <= 16'h0000;
      end else if (emit) begin
        pos_reg <= 16'(pos_reg + 16'h0001);
      end
      gap_reg <= (state_reg == ptx_pkg::PTX_ST_GAP) ? 4'(gap_reg + 4'h1) : 4'h0;
    end
  end

  // per-frame sideband latch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      side_reg <= '0;
    end else if (state_reg == ptx_pkg::PTX_ST_IDLE && ld && f_out.sop) begin
      side_reg <= f_out.side;
    end
  end

  // ----------------------------------------------------------------
  // timestamp capture at the pins
  // ----------------------------------------------------------------
  // running time plus fixed pin latency, ns wraps into seconds
  always_comb begin
    ns_sum = {1'b0, time_of_day_source[47:16]} + {1'b0, `PTX_PIN_LAT_NS};
    tod_adj = time_of_day_source;
    if (ns_sum >= {1'b0, `PTX_NS_PER_SEC}) begin
      tod_adj[95:48] = 48'(time_of_day_source[95:48] + 48'h1);
      tod_adj[47:16] = 32'(ns_sum - {1'b0, `PTX_NS_PER_SEC});
    end else begin
      tod_adj[47:16] = ns_sum[31:0];
    end
  end

  // taken as the first octet after the delimiter leaves
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ts_reg <= 96'h0;
      link.ts_valid <= 1'b0;
    end else begin
      link.ts_valid <= emit && pos_reg == `PTX_PRE_LEN;
      if (emit && pos_reg == `PTX_PRE_LEN) begin
        ts_reg <= tod_adj;
      end
    end
  end

  assign link.ts = ts_reg;
  assign link.ts_fp = side_reg.fingerprint;
  assign link.ts_ptp = side_reg.op != ptx_pkg::PTX_OP_NONE;

  // ----------------------------------------------------------------
  // one-step field values
  // ----------------------------------------------------------------
  always_comb begin
    if (ts_reg[47:16] >= side_reg.ingress_ns) begin
      resid = 32'(ts_reg[47:16] - side_reg.ingress_ns);
    end else begin
      resid = 32'(ts_reg[47:16] + `PTX_NS_PER_SEC - side_reg.ingress_ns);
    end
    corr_new = 64'(side_reg.corr_in + {16'h0, resid, 16'h0} + asym_corr + pdelay_corr);
    new_sum = 16'h0;
    for (int i = 0; i < 5; i++) begin
      new_sum = oc_add(new_sum, ts_reg[95-16*i -: 16]);
    end
    for (int i = 0; i < 4; i++) begin
      new_sum = oc_add(new_sum, corr_new[63-16*i -: 16]);
    end
    ext_new = oc_add(side_reg.csum_base, ~new_sum);
  end

  // ----------------------------------------------------------------
  // octet selection and rewrite
  // ----------------------------------------------------------------
  assign rel = 16'(pos_reg - `PTX_PRE_LEN);
  assign one = side_reg.op == ptx_pkg::PTX_OP_ONE_STEP;
  assign k_ts = 16'(rel - side_reg.ts_off);
  assign k_corr = 16'(rel - side_reg.corr_off);
  assign k_ext = 16'(rel - side_reg.ext_off);
  assign ts_sh = ts_reg[95:16] << {k_ts[3:0], 3'b000};
  assign corr_sh = corr_new << {k_corr[2:0], 3'b000};
  assign ext_sh = ext_new << {k_ext[0], 3'b000};
  assign raw_sh = w_reg.data << {bidx_reg, 3'b000};

  always_comb begin
    byte_next = raw_sh[`PTX_DATA_W-1 -: 8];
    if (state_reg == ptx_pkg::PTX_ST_PRE) begin
      byte_next = (pos_reg == `PTX_PRE_LEN - 16'h0001) ? `PTX_SFD_OCT : `PTX_PRE_OCT;
    end else if (one && pos_reg >= `PTX_PRE_LEN) begin
      if (rel >= side_reg.ts_off && k_ts < `PTX_TS_LEN) begin
        byte_next = ts_sh[79:72];
      end else if (rel >= side_reg.corr_off && k_corr < `PTX_CORR_LEN) begin
        byte_next = corr_sh[63:56];
      end else if (side_reg.udp == ptx_pkg::PTX_UDP_V4 && rel >= side_reg.csum_off &&
                   16'(rel - side_reg.csum_off) < `PTX_CSUM_LEN) begin
        byte_next = 8'h00;
      end else if (side_reg.udp == ptx_pkg::PTX_UDP_V6 && rel >= side_reg.ext_off &&
                   k_ext < `PTX_CSUM_LEN) begin
        byte_next = ext_sh[15:8];
      end
    end
  end

  // registered octet stream toward the pcs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pcs_byte <= 8'h00;
      pcs_valid <= 1'b0;
      pcs_sof <= 1'b0;
      pcs_eof <= 1'b0;
    end else begin
      pcs_byte <= emit ? byte_next : 8'h00;
      pcs_valid <= emit;
      pcs_sof <= emit && pos_reg == 16'h0000;
      pcs_eof <= state_reg == ptx_pkg::PTX_ST_DATA && have_reg && at_end && w_reg.eop;
    end
  end

endmodule

// ===== include/ptx_regs.svh
`ifndef PTX_REGS_SVH
`define PTX_REGS_SVH

// ----------------------------------------------------------------
// datapath geometry
// ----------------------------------------------------------------
`define PTX_DATA_W 512
`define PTX_EMPTY_W 6
`define PTX_FIFO_DEPTH 4

// ----------------------------------------------------------------
// preamble and delimiter octets
// ----------------------------------------------------------------
`define PTX_PRE_LEN 16'h0008
`define PTX_PRE_OCT 8'h55
`define PTX_SFD_OCT 8'hD5
`define PTX_PT_PREAMBLE 64'hFB555555555555D5
`define PTX_PT_SHIFT 6'h38

// ----------------------------------------------------------------
// one-step field lengths in octets
// ----------------------------------------------------------------
`define PTX_TS_LEN 16'h000A
`define PTX_CORR_LEN 16'h0008
`define PTX_CSUM_LEN 16'h0002

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PTX_IFG_OCT 4'hC
`define PTX_PIN_LAT_NS 32'h00000020
`define PTX_NS_PER_SEC 32'h3B9ACA00

`endif

// ===== include/ptx_pkg.sv
`include "ptx_regs.svh"

package ptx_pkg;

  typedef enum logic [1:0] {PTX_OP_NONE, PTX_OP_TWO_STEP, PTX_OP_ONE_STEP} ptx_op_t;
  typedef enum logic [1:0] {PTX_UDP_NONE, PTX_UDP_V4, PTX_UDP_V6} ptx_udp_t;

  // per-frame timing sideband, sampled with the start word
  typedef struct packed {
    ptx_op_t op;
    ptx_udp_t udp;
    logic [31:0] fingerprint;
    logic [15:0] ts_off;
    logic [15:0] corr_off;
    logic [15:0] csum_off;
    logic [15:0] ext_off;
    logic [63:0] corr_in;
    logic [31:0] ingress_ns;
    logic [15:0] csum_base;
  } ptx_side_t;

  typedef struct packed {
    logic [`PTX_DATA_W-1:0] data;
    logic sop;
    logic eop;
    logic [`PTX_EMPTY_W-1:0] empty;
    ptx_side_t side;
  } ptx_beat_t;

  typedef enum logic [1:0] {PTX_ST_IDLE, PTX_ST_PRE, PTX_ST_DATA, PTX_ST_GAP} ptx_tx_state_t;
  typedef enum logic {PTX_CL_PASS, PTX_CL_TAIL} ptx_cl_state_t;

endpackage

// ===== include/ptx_if.sv
`timescale 1ns/100ps

interface ptx_if;
  logic valid;
  logic ready;
  ptx_pkg::ptx_beat_t beat;
  logic pt_en;
  logic ts_valid;
  logic [95:0] ts;
  logic [31:0] ts_fp;
  logic ts_ptp;

  modport dev (
    input valid, beat, pt_en,
    output ready, ts_valid, ts, ts_fp, ts_ptp
  );
  modport cli (
    output valid, beat, pt_en,
    input ready, ts_valid, ts, ts_fp, ts_ptp
  );
endinterface

// ===== src/ptx_client.sv
`timescale 1ns/100ps
`include "ptx_regs.svh"

module ptx_client (
  input wire logic clock, // 200 MHz client clock
  input wire logic nrst, // async reset, active low
  ptx_if.cli link, // toward the mac
  input wire logic pt_en, // preamble pass-through mode
  input wire logic u_valid, // user word valid
  output logic u_ready, // user word taken
  input ptx_pkg::ptx_beat_t u_beat, // user word, no preamble
  output logic ts_valid, // timestamp pulse
  output logic [95:0] ts, // returned timestamp
  output logic [31:0] ts_fp, // returned fingerprint
  output logic ts_ptp // frame had a timing op
);

  ptx_pkg::ptx_cl_state_t st_reg;
  ptx_pkg::ptx_beat_t o_beat_reg;
  ptx_pkg::ptx_beat_t nb;
  ptx_pkg::ptx_beat_t tail_beat;
  logic o_valid_reg;
  logic pt_reg;
  logic [63:0] carry_reg;
  logic [`PTX_EMPTY_W-1:0] tail_empty_reg;
  logic space;
  logic take;

  assign space = !o_valid_reg || link.ready;
  assign u_ready = space && (st_reg == ptx_pkg::PTX_CL_PASS);
  assign take = u_valid && u_ready;
  assign link.valid = o_valid_reg;
  assign link.beat = o_beat_reg;
  assign link.pt_en = pt_reg;

  // ----------------------------------------------------------------
  // lane shaping of the next word
  // ----------------------------------------------------------------
  // msb octets first, highest lanes first; preamble shifts all by 8
  always_comb begin
    nb = u_beat;
    tail_beat = o_beat_reg;
    tail_beat.data = {carry_reg, {(`PTX_DATA_W-64){1'b0}}};
    tail_beat.sop = 1'b0;
    tail_beat.eop = 1'b1;
    tail_beat.empty = tail_empty_reg;
    if (pt_en) begin
      if (u_beat.sop) begin
        nb.data = {`PTX_PT_PREAMBLE, u_beat.data[`PTX_DATA_W-1:64]};
      end else begin
        nb.data = {carry_reg, u_beat.data[`PTX_DATA_W-1:64]};
      end
      if (u_beat.eop && u_beat.empty >= 6'h08) begin
        nb.empty = 6'(u_beat.empty - 6'h08);
      end else if (u_beat.eop) begin
        nb.eop = 1'b0;
        nb.empty = 6'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // output word register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      o_valid_reg <= 1'b0;
      o_beat_reg <= '0;
    end else if (take) begin
      o_valid_reg <= 1'b1;
      o_beat_reg <= nb;
    end else if (st_reg == ptx_pkg::PTX_CL_TAIL && space) begin
      o_valid_reg <= 1'b1;
      o_beat_reg <= tail_beat;
    end else if (link.ready) begin
      o_valid_reg <= 1'b0;
    end
  end

  // leftover octets and tail word state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ptx_pkg::PTX_CL_PASS;
      carry_reg <= 64'h0;
      tail_empty_reg <= 6'h00;
    end else begin
      if (take) begin
        carry_reg <= u_beat.data[63:0];
      end
      if (take && pt_en && u_beat.eop && u_beat.empty < 6'h08) begin
        st_reg <= ptx_pkg::PTX_CL_TAIL;
        tail_empty_reg <= 6'(u_beat.empty + `PTX_PT_SHIFT);
      end else if (st_reg == ptx_pkg::PTX_CL_TAIL && space) begin
        st_reg <= ptx_pkg::PTX_CL_PASS;
      end
    end
  end

  // mode level and returned timestamp
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pt_reg <= 1'b0;
      ts_valid <= 1'b0;
      ts <= 96'h0;
      ts_fp <= 32'h0;
      ts_ptp <= 1'b0;
    end else begin
      pt_reg <= pt_en;
      ts_valid <= link.ts_valid;
      if (link.ts_valid) begin
        ts <= link.ts;
        ts_fp <= link.ts_fp;
        ts_ptp <= link.ts_ptp;
      end
    end
  end

endmodule

// ===== testbench/ptx_link_sva.sv
`timescale 1ns/100ps
`include "ptx_regs.svh"

module ptx_link_sva (
  input wire logic clock, // client clock
  input wire logic nrst, // async reset, active low
  input wire logic valid, // word valid
  input wire logic ready, // fifo not full
  input ptx_pkg::ptx_beat_t beat, // word and sideband
  input wire logic pt_en, // pass-through mode
  input wire logic ts_valid, // timestamp pulse
  input wire logic [95:0] ts, // returned timestamp
  input wire logic [31:0] ts_fp, // returned fingerprint
  input wire logic ts_ptp // frame had a timing op
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  logic in_frame_reg;
  logic [7:0] pend_reg;
  wire take = valid && ready;

  // inside a frame between start and end words
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_frame_reg <= 1'b0;
    end else if (take) begin
      in_frame_reg <= !beat.eop;
    end
  end

  // frames taken but not yet stamped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pend_reg <= 8'h00;
    end else begin
      pend_reg <= pend_reg + 8'(take && beat.sop) - 8'(ts_valid);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pt_preamble_whole: assert property (
    valid && beat.sop && pt_en |-> beat.data[511:448] == `PTX_PT_PREAMBLE)
    else $error("pass-through start word lacks full preamble");
  a_pt_start_lane: assert property (
    valid && beat.sop && pt_en |-> beat.data[511:504] == 8'hFB)
    else $error("start octet not in top lane");
  a_pt_sfd_lane: assert property (
    valid && beat.sop && pt_en |-> beat.data[455:448] == `PTX_SFD_OCT)
    else $error("delimiter not in lane 455:448");
  a_word_hold_stable: assert property (
    valid && !ready |=> valid && $stable(beat))
    else $error("refused word changed or dropped");
  a_no_orphan_word: assert property (
    valid && !beat.sop |-> in_frame_reg)
    else $error("continuation word outside a frame");
  a_no_nested_start: assert property (
    valid && beat.sop |-> !in_frame_reg)
    else $error("start word inside an open frame");
  a_ts_single_pulse: assert property (
    ts_valid |=> !ts_valid)
    else $error("timestamp pulse longer than one cycle");
  a_ts_owned_frame: assert property (
    ts_valid |-> pend_reg != 8'h00)
    else $error("timestamp without an accepted frame");
  a_ts_moves_pulse: assert property (
    $changed(ts) |-> ts_valid)
    else $error("timestamp changed without pulse");
  a_fp_hold_stamp: assert property (
    ts_valid |-> $stable(ts_fp))
    else $error("fingerprint moved while stamp reported");

  c_pt_start: cover property (take && beat.sop && pt_en);
  c_fifo_full: cover property (valid && !ready);
  c_ts_timing: cover property (ts_valid && ts_ptp);
  c_eop_partial: cover property (take && beat.eop && beat.empty != 6'h00);
endmodule

// ===== testbench/ptx_tx_client_framing_test.sv
`timescale 1ns/100ps
`include "ptx_regs.svh"

module ptx_tx_client_framing_test;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [63:0] ASYM = 64'h0000_0000_0003_0000;
  localparam logic [63:0] PDLY = 64'h0000_0000_0001_8000;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic pt_en = 1'b0;
  logic u_valid = 1'b0;
  ptx_pkg::ptx_beat_t u_beat = '0;
  logic u_ready, ts_valid, ts_ptp, pcs_valid, pcs_sof, pcs_eof;
  logic [95:0] ts, c_ts, tod_exp;
  logic [31:0] ts_fp, c_fp;
  logic [31:0] tod_ns = 32'h0000_1000;
  logic [7:0] pcs_byte, sop_da;
  logic c_ptp, c_seen, eof_seen;
  logic saw_full = 1'b0;
  logic [7:0] cap[$];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int oct8_cyc = -1;
  int tsv_cyc = -2;

  ptx_if link_if();
  ptx_client u_ptx_client (.clock(clock), .nrst(nrst), .link(link_if), .pt_en(pt_en),
    .u_valid(u_valid), .u_ready(u_ready), .u_beat(u_beat), .ts_valid(ts_valid), .ts(ts),
    .ts_fp(ts_fp), .ts_ptp(ts_ptp));
  ptx_mac_tx u_ptx_mac_tx (.clock(clock), .nrst(nrst), .link(link_if),
    .time_of_day_source({48'h7, tod_ns, 16'h0}), .asym_corr(ASYM), .pdelay_corr(PDLY),
    .pcs_byte(pcs_byte), .pcs_valid(pcs_valid), .pcs_sof(pcs_sof), .pcs_eof(pcs_eof));
  ptx_link_sva u_ptx_link_sva (.clock(clock), .nrst(nrst), .valid(link_if.valid),
    .ready(link_if.ready), .beat(link_if.beat), .pt_en(link_if.pt_en),
    .ts_valid(link_if.ts_valid), .ts(link_if.ts), .ts_fp(link_if.ts_fp), .ts_ptp(link_if.ts_ptp));

  // clock and running time of day
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    #1;
    tod_ns = tod_ns + 32'h5;
  end

  // octet capture and timestamp watch
  always @(posedge clock) begin
    cyc++;
    if (pcs_valid === 1'b1) begin
      if (pcs_sof === 1'b1) cap.delete();
      cap.push_back(pcs_byte);
      if (cap.size() == 9) oct8_cyc = cyc;
      if (pcs_eof === 1'b1) eof_seen = 1'b1;
    end
    if (link_if.ts_valid === 1'b1) begin
      tsv_cyc = cyc;
      tod_exp = {48'h7, tod_ns - 32'h5 + `PTX_PIN_LAT_NS, 16'h0};
    end
    if (ts_valid === 1'b1) begin
      c_seen = 1'b1;
      c_ts = ts;
      c_fp = ts_fp;
      c_ptp = ts_ptp;
    end
    if (link_if.valid === 1'b1 && link_if.ready === 1'b1 && link_if.beat.sop === 1'b1)
      sop_da = link_if.beat.data[447:440];
    if (u_valid === 1'b1 && u_ready === 1'b0) saw_full = 1'b1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] fb(input int i);
    return 8'(i * 7 + 3);
  endfunction

  function automatic logic [15:0] ocs(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + 16'(s[16]);
  endfunction

  function automatic logic [95:0] grab(input int off, input int k);
    logic [95:0] v;
    v = '0;
    for (int j = 0; j < k; j++) v = {v[87:0], cap[8 + off + j]};
    return v;
  endfunction

  function automatic logic patched(input int i, input ptx_pkg::ptx_side_t sd);
    if (sd.op != ptx_pkg::PTX_OP_ONE_STEP) return 1'b0;
    return (i >= sd.ts_off && i < sd.ts_off + 10) || (i >= sd.corr_off && i < sd.corr_off + 8)
      || (sd.udp == ptx_pkg::PTX_UDP_V4 && i >= sd.csum_off && i < sd.csum_off + 2)
      || (sd.udp == ptx_pkg::PTX_UDP_V6 && i >= sd.ext_off && i < sd.ext_off + 2);
  endfunction

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one frame of n octets, msb lanes first, user side without preamble
  task automatic send_frame(input int n, input ptx_pkg::ptx_side_t sd);
    ptx_pkg::ptx_beat_t b;
    int nw;
    nw = (n + 63) / 64;
    for (int w = 0; w < nw; w++) begin
      b = '0;
      for (int k = 0; k < 64; k++) b.data[511 - 8 * k -: 8] = (w * 64 + k < n) ? fb(w * 64 + k) : 8'h00;
      b.sop = (w == 0);
      b.eop = (w == nw - 1);
      b.empty = (w == nw - 1) ? 6'(nw * 64 - n) : 6'h00;
      b.side = sd;
      u_beat = b;
      u_valid = 1'b1;
      @(posedge clock);
      while (u_ready !== 1'b1) @(posedge clock);
      #1;
    end
    u_valid = 1'b0;
  endtask

  // send, wait for the whole frame on the octet side, then compare
  task automatic run_frame(input int n, input logic pt, input ptx_pkg::ptx_side_t sd);
    logic [63:0] corr;
    logic [15:0] s;
    int to;
    @(posedge clock);
    #1;
    pt_en = pt;
    eof_seen = 1'b0;
    c_seen = 1'b0;
    send_frame(n, sd);
    to = 0;
    while (!(eof_seen === 1'b1 && c_seen === 1'b1) && to < 2000) begin
      @(posedge clock);
      to++;
    end
    check(96'(to < 2000), 96'h1);
    check(96'(cap.size()), 96'(n + 8));
    check(grab(-8, 8), pt ? `PTX_PT_PREAMBLE : {{7{`PTX_PRE_OCT}}, `PTX_SFD_OCT});
    if (pt) check(96'(sop_da), 96'(fb(0)));
    if (cap.size() >= n + 8)
      for (int i = 0; i < n; i++) if (!patched(i, sd)) check(96'(cap[8 + i]), 96'(fb(i)));
    check(96'(tsv_cyc == oct8_cyc), 96'h1);
    check(c_ts, tod_exp);
    check(96'(c_fp), 96'(sd.fingerprint));
    check(96'(c_ptp), 96'(sd.op != ptx_pkg::PTX_OP_NONE));
    if (sd.op == ptx_pkg::PTX_OP_ONE_STEP) begin
      corr = sd.corr_in + {16'h0, tod_exp[47:16] - sd.ingress_ns, 16'h0} + ASYM + PDLY;
      check(grab(sd.ts_off, 10), 96'(tod_exp[95:16]));
      check(grab(sd.corr_off, 8), 96'(corr));
      if (sd.udp == ptx_pkg::PTX_UDP_V4) check(grab(sd.csum_off, 2), 96'h0);
      if (sd.udp == ptx_pkg::PTX_UDP_V6) begin
        s = 16'h0;
        for (int i = 0; i < 5; i++) s = ocs(s, tod_exp[95 - 16 * i -: 16]);
        for (int i = 0; i < 4; i++) s = ocs(s, corr[63 - 16 * i -: 16]);
        check(grab(sd.ext_off, 2), 96'(ocs(sd.csum_base, ~s)));
      end
    end
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    ptx_pkg::ptx_side_t sd;
    repeat (10) @(posedge clock);
    #1;
    nrst = 1'b1;
    sd = '0;
    sd.op = ptx_pkg::PTX_OP_TWO_STEP;
    sd.fingerprint = 32'hA5C3_0001;
    run_frame(500, 1'b0, sd);
    check(96'(saw_full), 96'h1);
    sd.op = ptx_pkg::PTX_OP_NONE;
    sd.fingerprint = 32'h0000_0002;
    run_frame(60, 1'b1, sd);
    run_frame(64, 1'b1, sd);
    sd.op = ptx_pkg::PTX_OP_ONE_STEP;
    sd.udp = ptx_pkg::PTX_UDP_V4;
    sd.ts_off = 16'h000E;
    sd.corr_off = 16'h0018;
    sd.csum_off = 16'h0024;
    sd.ext_off = 16'h0030;
    sd.corr_in = 64'h0000_0000_0010_0000;
    sd.ingress_ns = 32'h0000_0100;
    sd.csum_base = 16'h1234;
    sd.fingerprint = 32'h0000_0003;
    run_frame(64, 1'b0, sd);
    sd.udp = ptx_pkg::PTX_UDP_V6;
    sd.fingerprint = 32'h0000_0004;
    run_frame(72, 1'b1, sd);
    end_of_test();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clock);
    failures++;
    end_of_test();
  end
endmodule
